/* File: include/operand_format_pkg.sv */
package operand_format_pkg;

    // ==========================================================
    // Word, byte and digit geometry
    // ==========================================================
    localparam int WORD_W    = 16;
    localparam int DWORD_W   = 32;
    localparam int BYTE_W    = 8;
    localparam int HEX_W     = 4;
    localparam int NUM_REGS  = 16;
    localparam int REG_SEL_W = 4;
    localparam int SEL_W     = 2;

    // Vector bit 15 is bit 0 (most significant end) of a word
    localparam int BYTE0_LSB = 8;
    localparam int BYTE1_LSB = 0;
    localparam int DIG0_LSB  = 12;

    // Register zero is the operator switch register
    localparam logic [3:0] SWITCH_REG_SEL = 4'h0;
    localparam logic [3:0] PAIR_ODD_BIT   = 4'h1;

    // ==========================================================
    // Floating-point layout (single form held in a doubleword)
    // ==========================================================
    localparam int FP_EXP_W      = 9;
    localparam int FP_FRAC_SGL_W = 22;
    localparam int FP_FRAC_DBL_W = 38;
    localparam int FP_SIGN_POS   = 31;
    localparam int FP_EXP_LSB    = 22;

    localparam logic [15:0] WORD_ZERO  = 16'h0000;
    localparam logic [31:0] DWORD_ZERO = 32'h0000_0000;
    localparam logic [15:0] ADDR_STEP  = 16'h0001;

    // ==========================================================
    // Operations
    // ==========================================================
    typedef enum logic [2:0] {
        OP_PASS  = 3'h0,
        OP_NEG   = 3'h1,
        OP_CMP   = 3'h3,
        OP_BYTE  = 3'h2,
        OP_HEX   = 3'h6,
        OP_FNORM = 3'h7,
        OP_FNEG  = 3'h5
    } op_e;

    typedef struct packed {
        op_e                   op;
        logic                  dw;
        logic [SEL_W-1:0]      sel;
        logic [REG_SEL_W-1:0]  src_a;
        logic [REG_SEL_W-1:0]  src_b;
    } req_s;

    typedef struct packed {
        logic neg;
        logic zero;
        logic less;
        logic equal;
    } flags_s;

endpackage

/* File: verilog/operand_format_datapath.sv */
`timescale 1ns/1ps
// Overview of operation
// RL1: Doubleword is 32 bits in two locations
// RL2: Even register high half, next odd low
// RL3: Byte 0 bits 0-7, byte 1 bits 8-15
// RL4: Four hex digits, digit 0 most significant
// RL5: Sign bit leads 15 or 31 data bits
// RL6: Negatives are two's complement, both lengths
// RL7: Float: nine-bit exponent, 22/38-bit fraction
// RL8: Zero fraction forces all-zero float word
// RL9: Float negate is integer two's complement
// RL10: Memory doubleword high word at lower address
// RL11: Four-bit register fields, R0 is switches
module operand_format_datapath (
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST,
    // Operator switches (register zero)
    input  wire logic [15:0]                   SWITCH_REG,
    // Register write port
    input  wire logic                          WR_EN,
    input  wire logic                          WR_DW,
    input  wire logic [3:0]                    WR_ADDR,
    input  wire logic [31:0]                   WR_DATA,
    // Operation request
    input  wire logic                          REQ_VALID,
    input  wire operand_format_pkg::req_s      REQ,
    // Memory doubleword address split
    input  wire logic [15:0]                   MEM_DW_ADDR,
    output logic      [15:0]                   MEM_HI_ADDR,
    output logic      [15:0]                   MEM_LO_ADDR,
    // Results
    output logic                               RES_VALID,
    output logic      [31:0]                   RESULT,
    output operand_format_pkg::flags_s         FLAGS
);

    // ==========================================================
    // General register file
    // ==========================================================
    logic [15:0] regs_ff     [1:15];
    logic [15:0] nxt_regs    [1:15];
    logic [3:0]  wr_even;

    always_comb begin
        wr_even = WR_ADDR & ~operand_format_pkg::PAIR_ODD_BIT;
        for (int i = 1; i < operand_format_pkg::NUM_REGS; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        if (WR_EN) begin
            if (WR_DW) begin
                // Writes to the switch register are dropped [RL11]
                if (wr_even != operand_format_pkg::SWITCH_REG_SEL) begin
                    nxt_regs[wr_even] = WR_DATA[31:16]; // [RL2]
                end
                nxt_regs[wr_even | operand_format_pkg::PAIR_ODD_BIT] = WR_DATA[15:0]; // [RL2]
            end else if (WR_ADDR != operand_format_pkg::SWITCH_REG_SEL) begin
                nxt_regs[WR_ADDR] = WR_DATA[15:0];
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 1; i < operand_format_pkg::NUM_REGS; i++) begin
                regs_ff[i] <= operand_format_pkg::WORD_ZERO;
            end
        end else begin
            for (int i = 1; i < operand_format_pkg::NUM_REGS; i++) begin
                regs_ff[i] <= nxt_regs[i];
            end
        end
    end

    function automatic logic [15:0] rd_word(input logic [3:0] sel, input logic [15:0] sw,
                                            input logic [15:0] r1, input logic [15:0] r2);
        rd_word = (sel == operand_format_pkg::SWITCH_REG_SEL) ? sw : ((sel[0]) ? r2 : r1); // [RL11]
    endfunction

    // ==========================================================
    // Operand fetch
    // ==========================================================
    logic [3:0]  a_even;
    logic [3:0]  b_even;
    logic [15:0] a_hi;
    logic [15:0] a_lo;
    logic [15:0] b_hi;
    logic [15:0] b_lo;
    logic [15:0] a_sgl;
    logic [15:0] b_sgl;
    logic [31:0] opa;
    logic [31:0] opb;

    always_comb begin
        a_even = REQ.src_a & ~operand_format_pkg::PAIR_ODD_BIT;
        b_even = REQ.src_b & ~operand_format_pkg::PAIR_ODD_BIT;
        a_hi   = (a_even == operand_format_pkg::SWITCH_REG_SEL) ? SWITCH_REG : regs_ff[a_even];
        b_hi   = (b_even == operand_format_pkg::SWITCH_REG_SEL) ? SWITCH_REG : regs_ff[b_even];
        a_lo   = regs_ff[a_even | operand_format_pkg::PAIR_ODD_BIT];
        b_lo   = regs_ff[b_even | operand_format_pkg::PAIR_ODD_BIT];
        a_sgl  = rd_word(REQ.src_a, SWITCH_REG, a_hi, a_lo);
        b_sgl  = rd_word(REQ.src_b, SWITCH_REG, b_hi, b_lo);
        if (REQ.dw) begin
            opa = {a_hi, a_lo}; // [RL1] [RL2]
            opb = {b_hi, b_lo}; // [RL1] [RL2]
        end else begin
            // Single length sign-extended from bit 0 [RL5]
            opa = {{operand_format_pkg::WORD_W{a_sgl[operand_format_pkg::WORD_W-1]}}, a_sgl};
            opb = {{operand_format_pkg::WORD_W{b_sgl[operand_format_pkg::WORD_W-1]}}, b_sgl};
        end
    end

    // ==========================================================
    // Arithmetic and format units
    // ==========================================================
    function automatic logic [31:0] fp_norm(input logic [31:0] v);
        logic [31:0] mag;
        mag = v[operand_format_pkg::FP_SIGN_POS] ? (~v + 32'h0000_0001) : v; // [RL9]
        if (mag[operand_format_pkg::FP_FRAC_SGL_W-1:0] == '0) begin
            fp_norm = operand_format_pkg::DWORD_ZERO; // [RL8]
        end else begin
            fp_norm = v; // [RL7]
        end
    endfunction

    logic [31:0]                 nxt_result;
    operand_format_pkg::flags_s  nxt_flags;
    logic [31:0]                 result_ff;
    operand_format_pkg::flags_s  flags_ff;
    logic                        res_valid_ff;
    logic [31:0]                 neg_full;
    logic                        sgn;

    always_comb begin
        neg_full   = ~opa + 32'h0000_0001; // [RL6]
        nxt_result = opa;
        case (REQ.op)
            operand_format_pkg::OP_PASS:  nxt_result = opa;
            operand_format_pkg::OP_NEG:   nxt_result = neg_full; // [RL6]
            operand_format_pkg::OP_CMP:   nxt_result = opa;
            operand_format_pkg::OP_BYTE:  nxt_result = REQ.sel[0] ?
                {24'h00_0000, opa[operand_format_pkg::BYTE1_LSB +: operand_format_pkg::BYTE_W]} :
                {24'h00_0000, opa[operand_format_pkg::BYTE0_LSB +: operand_format_pkg::BYTE_W]}; // [RL3]
            operand_format_pkg::OP_HEX:   nxt_result = {28'h000_0000,
                opa[operand_format_pkg::DIG0_LSB - 4*REQ.sel +: operand_format_pkg::HEX_W]}; // [RL4]
            operand_format_pkg::OP_FNORM: nxt_result = fp_norm(opa); // [RL8]
            operand_format_pkg::OP_FNEG:  nxt_result = fp_norm(neg_full); // [RL9]
            default:                      nxt_result = opa;
        endcase
        if (!REQ.dw && REQ.op != operand_format_pkg::OP_FNORM && REQ.op != operand_format_pkg::OP_FNEG) begin
            nxt_result[31:16] = operand_format_pkg::WORD_ZERO;
        end
        sgn             = REQ.dw ? nxt_result[31] : nxt_result[15]; // [RL5]
        nxt_flags.neg   = (REQ.op == operand_format_pkg::OP_BYTE || REQ.op == operand_format_pkg::OP_HEX) ?
                          1'b0 : sgn;
        nxt_flags.zero  = (nxt_result == operand_format_pkg::DWORD_ZERO);
        nxt_flags.less  = (REQ.op == operand_format_pkg::OP_CMP) && ($signed(opa) < $signed(opb)); // [RL6]
        nxt_flags.equal = (REQ.op == operand_format_pkg::OP_CMP) && (opa == opb);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            result_ff    <= operand_format_pkg::DWORD_ZERO;
            flags_ff     <= '0;
            res_valid_ff <= 1'b0;
        end else begin
            res_valid_ff <= REQ_VALID;
            if (REQ_VALID) begin
                result_ff <= nxt_result;
                flags_ff  <= nxt_flags;
            end
        end
    end

    // ==========================================================
    // Memory doubleword addressing
    // ==========================================================
    logic [15:0] mem_hi_ff;
    logic [15:0] mem_lo_ff;
    logic [15:0] nxt_mem_lo;

    always_comb begin
        nxt_mem_lo = MEM_DW_ADDR + operand_format_pkg::ADDR_STEP; // [RL10]
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mem_hi_ff <= operand_format_pkg::WORD_ZERO;
            mem_lo_ff <= operand_format_pkg::WORD_ZERO;
        end else begin
            mem_hi_ff <= MEM_DW_ADDR;
            mem_lo_ff <= nxt_mem_lo;
        end
    end

    assign MEM_HI_ADDR = mem_hi_ff;
    assign MEM_LO_ADDR = mem_lo_ff;
    assign RESULT      = result_ff;
    assign FLAGS       = flags_ff;
    assign RES_VALID   = res_valid_ff;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_mem_pair;
        @(posedge CLK) disable iff (RST)
        1'b1 |=> (MEM_LO_ADDR == MEM_HI_ADDR + 16'h0001) && (MEM_HI_ADDR == $past(MEM_DW_ADDR));
    endproperty
    a_mem_pair: assert property (p_mem_pair) else $error("memory pair order wrong"); // [RL10]

    property p_dw_pair;
        @(posedge CLK) disable iff (RST)
        (WR_EN && WR_DW && WR_ADDR[3:1] != 3'h0) ##1 !WR_EN ##1 (REQ_VALID && REQ.op == operand_format_pkg::OP_PASS
            && REQ.dw && REQ.src_a == $past(WR_ADDR, 2)) |=> RESULT == $past(WR_DATA, 3);
    endproperty
    a_dw_pair: assert property (p_dw_pair) else $error("doubleword pairing wrong"); // [RL2]

    property p_dw_width;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_PASS && REQ.dw) |=> RESULT == {$past(a_hi), $past(a_lo)};
    endproperty
    a_dw_width: assert property (p_dw_width) else $error("doubleword not 32 bits"); // [RL1]

    property p_byte;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_BYTE && REQ.sel[0] == 1'b0)
            |=> RESULT[7:0] == $past(opa[15:8]) && RESULT[31:8] == 24'h00_0000;
    endproperty
    a_byte: assert property (p_byte) else $error("byte 0 position wrong"); // [RL3]

    property p_hex;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_HEX && REQ.sel == 2'h0)
            |=> RESULT == {28'h0, $past(opa[15:12])};
    endproperty
    a_hex: assert property (p_hex) else $error("top hex digit wrong"); // [RL4]

    property p_neg;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_NEG && REQ.dw) |=> RESULT + $past(opa) == 32'h0;
    endproperty
    a_neg: assert property (p_neg) else $error("negate not two's complement"); // [RL6]

    property p_sign;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_PASS && !REQ.dw) |=> FLAGS.neg == RESULT[15];
    endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong"); // [RL5]

    property p_fzero;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_FNORM && opa[21:0] == 22'h0) |=> RESULT == 32'h0 && FLAGS.zero;
    endproperty
    a_fzero: assert property (p_fzero) else $error("zero fraction kept exponent"); // [RL8]

    property p_fneg;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_FNEG && opa[21:0] != 22'h0) |=> RESULT == -$past(opa);
    endproperty
    a_fneg: assert property (p_fneg) else $error("float negate wrong"); // [RL9]

    property p_r0;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_PASS && !REQ.dw && REQ.src_a == 4'h0)
            |=> RESULT[15:0] == $past(SWITCH_REG);
    endproperty
    a_r0: assert property (p_r0) else $error("register zero not switches"); // [RL11]

    property p_fexp;
        @(posedge CLK) disable iff (RST)
        (REQ_VALID && REQ.op == operand_format_pkg::OP_FNORM && opa[21:0] != 22'h0)
            |=> RESULT[30:22] == $past(opa[30:22]);
    endproperty
    a_fexp: assert property (p_fexp) else $error("exponent field disturbed"); // [RL7]

    c_dw_neg: cover property (@(posedge CLK) disable iff (RST)
        REQ_VALID && REQ.op == operand_format_pkg::OP_NEG && REQ.dw);
    c_cmp_less: cover property (@(posedge CLK) disable iff (RST) RES_VALID && FLAGS.less);
    c_fzero: cover property (@(posedge CLK) disable iff (RST)
        REQ_VALID && REQ.op == operand_format_pkg::OP_FNORM && opa != 32'h0 && opa[21:0] == 22'h0);
    c_dw_write: cover property (@(posedge CLK) disable iff (RST) WR_EN && WR_DW);

endmodule

/* File: verif/reg_file_model.sv */
`timescale 1ns/1ps
// =====================================================
// Register file loader and operator panel
// =====================================================
module reg_file_model (
    // Clock
    input  wire logic        CLK,
    // Write port toward the datapath
    output logic             wr_en,
    output logic             wr_dw,
    output logic [3:0]       wr_addr,
    output logic [31:0]      wr_data,
    // Operator switches
    output logic [15:0]      switch_reg
);
    initial begin
        wr_en      = 1'b0;
        wr_dw      = 1'b0;
        wr_addr    = 4'hF;
        wr_data    = 32'h0000_0000;
        switch_reg = 16'h0000;
    end

    // One write; a doubleword puts high half to even, low half to odd register
    task automatic put(input logic dw, input logic [3:0] a, input logic [31:0] d);
        @(negedge CLK);
        wr_en   = 1'b1;
        wr_dw   = dw;
        wr_addr = a;
        wr_data = d;
        @(negedge CLK);
        // Released address and data show the inverse, not a stale value
        wr_en   = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
    endtask

    task automatic set_switch(input logic [15:0] v);
        @(negedge CLK);
        switch_reg = v;
    endtask
endmodule

/* File: verif/operand_format_datapath_test.sv */
`timescale 1ns/1ps
module operand_format_datapath_test;
    logic                        clk;
    logic                        rst;
    logic                        wr_en;
    logic                        wr_dw;
    logic [3:0]                  wr_addr;
    logic [31:0]                 wr_data;
    logic [15:0]                 switch_reg;
    logic                        req_valid;
    operand_format_pkg::req_s    req;
    logic [15:0]                 mem_dw_addr;
    logic [15:0]                 mem_hi_addr;
    logic [15:0]                 mem_lo_addr;
    logic                        res_valid;
    logic [31:0]                 result;
    operand_format_pkg::flags_s  flags;
    int                          fail_count;
    int                          num_checks;

    operand_format_datapath dut (.CLK(clk), .RST(rst), .SWITCH_REG(switch_reg), .WR_EN(wr_en), .WR_DW(wr_dw),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .REQ_VALID(req_valid), .REQ(req), .MEM_DW_ADDR(mem_dw_addr),
        .MEM_HI_ADDR(mem_hi_addr), .MEM_LO_ADDR(mem_lo_addr), .RES_VALID(res_valid), .RESULT(result),
        .FLAGS(flags));

    reg_file_model pm (.CLK(clk), .wr_en(wr_en), .wr_dw(wr_dw), .wr_addr(wr_addr), .wr_data(wr_data),
        .switch_reg(switch_reg));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // =====================================================
    // Shared helpers
    // =====================================================
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic run_op(input operand_format_pkg::op_e o, input logic dw, input logic [1:0] s,
                          input logic [3:0] a, input logic [3:0] b);
        @(negedge clk);
        req_valid = 1'b1;
        req.op    = o;
        req.dw    = dw;
        req.sel   = s;
        req.src_a = a;
        req.src_b = b;
        @(negedge clk);
        req_valid = 1'b0;
        chk("res_valid", 32'h1, {31'h0, res_valid});
    endtask

    task automatic close_out;
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // =====================================================
    // Scenarios
    // =====================================================
    task automatic t_reset;
        chk("rst result", 32'h0, result);
        chk("rst valid", 32'h0, {31'h0, res_valid});
    endtask

    task automatic t_pair;
        pm.put(1'b1, 4'h3, 32'h8000_0001);
        run_op(operand_format_pkg::OP_PASS, 1'b1, 2'h0, 4'h3, 4'h0);
        chk("dw pass", 32'h8000_0001, result);
        chk("dw neg flag", 32'h1, {31'h0, flags.neg});
        run_op(operand_format_pkg::OP_PASS, 1'b0, 2'h0, 4'h3, 4'h0);
        chk("odd half", 32'h0000_0001, result);
        run_op(operand_format_pkg::OP_PASS, 1'b0, 2'h0, 4'h2, 4'h0);
        chk("even half", 32'h0000_8000, result);
        chk("sgl neg flag", 32'h1, {31'h0, flags.neg});
    endtask

    task automatic t_neg;
        pm.put(1'b0, 4'h5, 32'h0000_0003);
        run_op(operand_format_pkg::OP_NEG, 1'b0, 2'h0, 4'h5, 4'h0);
        chk("neg sgl", 32'h0000_FFFD, result);
        run_op(operand_format_pkg::OP_NEG, 1'b1, 2'h0, 4'h2, 4'h0);
        chk("neg dw", 32'h7FFF_FFFF, result);
        chk("neg dw flag", 32'h0, {31'h0, flags.neg});
    endtask

    task automatic t_fields;
        pm.put(1'b0, 4'h7, 32'h0000_A55A);
        pm.put(1'b0, 4'h6, 32'h0000_1234);
        for (int s = 0; s < 2; s++) begin
            run_op(operand_format_pkg::OP_BYTE, 1'b0, s[1:0], 4'h7, 4'h0);
            chk("byte", (s == 0) ? 32'h0000_00A5 : 32'h0000_005A, result);
        end
        for (int s = 0; s < 4; s++) begin
            run_op(operand_format_pkg::OP_HEX, 1'b0, s[1:0], 4'h6, 4'h0);
            chk("hex digit", 32'(s + 1), result);
        end
    endtask

    task automatic t_cmp;
        run_op(operand_format_pkg::OP_CMP, 1'b0, 2'h0, 4'h5, 4'h6);
        chk("cmp lt", 32'h2, {30'h0, flags.less, flags.equal});
        chk("cmp res", 32'h0000_0003, result);
        run_op(operand_format_pkg::OP_CMP, 1'b0, 2'h0, 4'h6, 4'h6);
        chk("cmp eq", 32'h1, {30'h0, flags.less, flags.equal});
        run_op(operand_format_pkg::OP_CMP, 1'b0, 2'h0, 4'h6, 4'h5);
        chk("cmp gt", 32'h0, {30'h0, flags.less, flags.equal});
        run_op(operand_format_pkg::OP_CMP, 1'b0, 2'h0, 4'h7, 4'h6);
        chk("cmp signed", 32'h2, {30'h0, flags.less, flags.equal});
    endtask

    task automatic t_float;
        pm.put(1'b1, 4'h8, 32'h0040_0000);
        pm.put(1'b1, 4'hA, 32'h0040_1000);
        run_op(operand_format_pkg::OP_FNORM, 1'b1, 2'h0, 4'h8, 4'h0);
        chk("fnorm zero", 32'h0, result);
        chk("zero flag", 32'h1, {31'h0, flags.zero});
        run_op(operand_format_pkg::OP_FNORM, 1'b1, 2'h0, 4'hA, 4'h0);
        chk("fnorm keep", 32'h0040_1000, result);
        run_op(operand_format_pkg::OP_FNEG, 1'b1, 2'h0, 4'hA, 4'h0);
        chk("fneg", 32'hFFBF_F000, result);
        run_op(operand_format_pkg::OP_FNEG, 1'b1, 2'h0, 4'h8, 4'h0);
        chk("fneg zero", 32'h0, result);
    endtask

    task automatic t_mem;
        logic [15:0] a [2];
        a[0] = 16'h1234;
        a[1] = 16'hFFFF;
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            mem_dw_addr = a[i];
            @(negedge clk);
            chk("mem hi", {16'h0, a[i]}, {16'h0, mem_hi_addr});
            chk("mem lo", {16'h0, a[i] + 16'h0001}, {16'h0, mem_lo_addr});
        end
    endtask

    task automatic t_switch;
        pm.set_switch(16'h8001);
        pm.put(1'b0, 4'h0, 32'h0000_5555);
        run_op(operand_format_pkg::OP_PASS, 1'b0, 2'h0, 4'h0, 4'h0);
        chk("switch reg", 32'h0000_8001, result);
        pm.put(1'b1, 4'h0, 32'hFFFF_0042);
        run_op(operand_format_pkg::OP_PASS, 1'b1, 2'h0, 4'h1, 4'h0);
        chk("pair zero", 32'h8001_0042, result);
    endtask

    // =====================================================
    // Main sequence and hang guard
    // =====================================================
    initial begin
        rst         = 1'b1;
        req_valid   = 1'b0;
        req         = '0;
        mem_dw_addr = 16'h0000;
        fail_count  = 0;
        num_checks  = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_pair();
        t_neg();
        t_fields();
        t_cmp();
        t_float();
        t_mem();
        t_switch();
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule
